// File: iecs_pkg.sv
`default_nettype none
package iecs_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned BANK_LSB     = 7;
  localparam logic [4:0]  SHADOW_BANK  = 5'h1f;
  localparam logic [11:0] CTRL_ADDR    = 12'h00b;
  localparam logic [11:0] STAT_ADDR    = 12'h00c;
  localparam logic [11:0] EN0_ADDR     = 12'h090;
  localparam logic [11:0] EN1_ADDR     = 12'h091;
  localparam logic [11:0] PINSEL_ADDR  = 12'h0a0;
  localparam logic [6:0]  SHADOW_BASE  = 7'h64;
  localparam int unsigned SHADOW_COUNT = 8;

  // shadow slot order
  localparam int unsigned SH_W      = 0;
  localparam int unsigned SH_STATUS = 1;
  localparam int unsigned SH_BANK   = 2;
  localparam int unsigned SH_PCHI   = 3;
  localparam int unsigned SH_FSR0L  = 4;
  localparam int unsigned SH_FSR0H  = 5;
  localparam int unsigned SH_FSR1L  = 6;
  localparam int unsigned SH_FSR1H  = 7;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned GEN_BIT   = 7;
  localparam int unsigned GRP_BIT   = 6;
  localparam int unsigned EDGE_BIT  = 0;
  localparam int unsigned TMR0_BIT  = 5;
  localparam int unsigned IOC_BIT   = 4;
  localparam int unsigned EXT_BIT   = 0;
  localparam int unsigned EXTF_BIT  = 0;
  localparam int unsigned SERVE_BIT = 1;
  localparam int unsigned LEVEL_BIT = 2;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0]  CTRL_RESET       = 8'h01;
  localparam logic [7:0]  EN0_RESET        = 8'h00;
  localparam logic [7:0]  EN1_RESET        = 8'h00;
  localparam logic [7:0]  CTRL_MASK        = 8'hc1;
  localparam logic [7:0]  EN0_MASK         = 8'h31;
  localparam logic [7:0]  STATUS_SAVE_MASK = 8'he7;
  localparam logic [14:0] IRQ_VECTOR       = 15'h0004;

  // ****************************************************************
  // entry sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    IECS_IDLE  = 3'b001,
    IECS_VECT  = 3'b010,
    IECS_SERVE = 3'b100
  } iecs_state_type;

endpackage : iecs_pkg
`default_nettype wire

// File: iecs_irq_ctrl.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module iecs_irq_ctrl #(
  parameter int unsigned PIN_COUNT = 8,
  parameter int unsigned SEL_W     = 3
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [iecs_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [7:0]                 rdata,
  input  wire logic [PIN_COUNT-1:0]       gpio_pins,
  input  wire logic                       tmr0_flag,
  input  wire logic                       ioc_flag,
  input  wire logic [7:0]                 periph_flags,
  input  wire logic                       core_irq_return,
  input  wire logic [14:0]                core_pc,
  input  wire logic [7:0]                 core_w,
  input  wire logic [7:0]                 core_status,
  input  wire logic [7:0]                 core_bank_sel,
  input  wire logic [7:0]                 core_pc_hi,
  input  wire logic [7:0]                 core_fsr0l,
  input  wire logic [7:0]                 core_fsr0h,
  input  wire logic [7:0]                 core_fsr1l,
  input  wire logic [7:0]                 core_fsr1h,
  output logic                            flush,
  output logic                            stack_push,
  output logic      [14:0]                push_pc,
  output logic                            pc_load,
  output logic      [14:0]                pc_load_val,
  output logic                            stack_pop,
  output logic                            ctx_restore,
  output logic      [7:0]                 rst_w,
  output logic      [7:0]                 rst_status,
  output logic      [7:0]                 rst_bank_sel,
  output logic      [7:0]                 rst_pc_hi,
  output logic      [7:0]                 rst_fsr0l,
  output logic      [7:0]                 rst_fsr0h,
  output logic      [7:0]                 rst_fsr1l,
  output logic      [7:0]                 rst_fsr1h,
  output logic                            global_irq_enable
);

  // ****************************************************************
  // state
  // ****************************************************************
  iecs_pkg::iecs_state_type state_r;
  iecs_pkg::iecs_state_type state_nxt;
  logic [7:0]       ctrl_r;
  logic [7:0]       en0_r;
  logic [7:0]       en1_r;
  logic [SEL_W-1:0] pin_sel_r;
  logic             ext_flag_r;
  logic             ext_flag_nxt;
  logic             sync1_r;
  logic             sync2_r;
  logic             sync3_r;
  logic             level_r;
  logic             pend_r;
  logic             flush_r;
  logic             push_r;
  logic [14:0]      push_pc_r;
  logic             pc_load_r;
  logic [14:0]      pc_load_val_r;
  logic             pop_r;
  logic             restore_r;
  logic [7:0]       rdata_r;
  logic [7:0]       shadow_r [iecs_pkg::SHADOW_COUNT];
  logic [7:0]       ctx_in   [iecs_pkg::SHADOW_COUNT];

  // ****************************************************************
  // decode
  // ****************************************************************
  wire       wr_ctrl   = wr && (addr == iecs_pkg::CTRL_ADDR);
  wire       wr_stat   = wr && (addr == iecs_pkg::STAT_ADDR);
  wire       wr_en0    = wr && (addr == iecs_pkg::EN0_ADDR);
  wire       wr_en1    = wr && (addr == iecs_pkg::EN1_ADDR);
  wire       wr_pinsel = wr && (addr == iecs_pkg::PINSEL_ADDR);
  wire [6:0] sh_off    = addr[6:0] - iecs_pkg::SHADOW_BASE;
  wire       sh_hit    = (addr[11:iecs_pkg::BANK_LSB] == iecs_pkg::SHADOW_BANK) &&
                         (addr[6:0] >= iecs_pkg::SHADOW_BASE) && (sh_off < 7'h08);
  wire [2:0] sh_idx    = sh_off[2:0];

  wire glb_en = ctrl_r[iecs_pkg::GEN_BIT];
  wire grp_en = ctrl_r[iecs_pkg::GRP_BIT];
  wire edge_r = ctrl_r[iecs_pkg::EDGE_BIT];

  // ****************************************************************
  // external pin select and edge detect
  // ****************************************************************
  wire sel_pin  = gpio_pins[pin_sel_r];
  wire stable   = (sync2_r == sync3_r);
  wire ext_edge = stable && (level_r != sync3_r) && (sync3_r == edge_r);
  wire ext_clr  = wr_stat && !wdata[iecs_pkg::EXTF_BIT];

  always_comb begin
    ext_flag_nxt = ext_flag_r;
    if (ext_clr) begin
      ext_flag_nxt = 1'b0;
    end
    if (ext_edge) begin
      ext_flag_nxt = 1'b1;
    end
  end

  // ****************************************************************
  // gating
  // ****************************************************************
  wire [2:0] src0 = {tmr0_flag  & en0_r[iecs_pkg::TMR0_BIT],
                     ioc_flag   & en0_r[iecs_pkg::IOC_BIT],
                     ext_flag_r & en0_r[iecs_pkg::EXT_BIT]};
  wire [7:0] src1 = periph_flags & en1_r;
  wire pend_nxt   = glb_en && ((|src0) || (grp_en && (|src1)));
  wire take       = pend_r && glb_en && (state_r != iecs_pkg::IECS_VECT);
  wire ret_ok     = core_irq_return && (state_r != iecs_pkg::IECS_VECT);

  always_comb begin
    case (state_r)
      iecs_pkg::IECS_IDLE:  state_nxt = take ? iecs_pkg::IECS_VECT : iecs_pkg::IECS_IDLE;
      iecs_pkg::IECS_VECT:  state_nxt = iecs_pkg::IECS_SERVE;
      iecs_pkg::IECS_SERVE: state_nxt = take   ? iecs_pkg::IECS_VECT :
                                        ret_ok ? iecs_pkg::IECS_IDLE : iecs_pkg::IECS_SERVE;
      default:              state_nxt = iecs_pkg::IECS_IDLE;
    endcase
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  wire [7:0] stat_val = {5'h00, level_r, (state_r == iecs_pkg::IECS_SERVE), ext_flag_r};
  wire [7:0] rd_val   = (addr == iecs_pkg::CTRL_ADDR)   ? ctrl_r :
                        (addr == iecs_pkg::STAT_ADDR)   ? stat_val :
                        (addr == iecs_pkg::EN0_ADDR)    ? en0_r :
                        (addr == iecs_pkg::EN1_ADDR)    ? en1_r :
                        (addr == iecs_pkg::PINSEL_ADDR) ? {{(8-SEL_W){1'b0}}, pin_sel_r} :
                        sh_hit                          ? shadow_r[sh_idx] : 8'h00;

  assign ctx_in[iecs_pkg::SH_W]      = core_w;
  assign ctx_in[iecs_pkg::SH_STATUS] = core_status & iecs_pkg::STATUS_SAVE_MASK;
  assign ctx_in[iecs_pkg::SH_BANK]   = core_bank_sel;
  assign ctx_in[iecs_pkg::SH_PCHI]   = core_pc_hi;
  assign ctx_in[iecs_pkg::SH_FSR0L]  = core_fsr0l;
  assign ctx_in[iecs_pkg::SH_FSR0H]  = core_fsr0h;
  assign ctx_in[iecs_pkg::SH_FSR1L]  = core_fsr1l;
  assign ctx_in[iecs_pkg::SH_FSR1H]  = core_fsr1h;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= iecs_pkg::CTRL_RESET;
    end else if (take) begin
      ctrl_r[iecs_pkg::GEN_BIT] <= 1'b0;
    end else if (ret_ok) begin
      ctrl_r[iecs_pkg::GEN_BIT] <= 1'b1;
    end else if (wr_ctrl) begin
      ctrl_r <= wdata & iecs_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en0_r     <= iecs_pkg::EN0_RESET;
      en1_r     <= iecs_pkg::EN1_RESET;
      pin_sel_r <= '0;
    end else begin
      if (wr_en0) en0_r <= wdata & iecs_pkg::EN0_MASK;
      if (wr_en1) en1_r <= wdata;
      if (wr_pinsel) pin_sel_r <= wdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      sync3_r    <= 1'b0;
      level_r    <= 1'b0;
      ext_flag_r <= 1'b0;
      pend_r     <= 1'b0;
    end else begin
      sync1_r    <= sel_pin;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      level_r    <= stable ? sync3_r : level_r;
      ext_flag_r <= ext_flag_nxt;
      pend_r     <= pend_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r       <= iecs_pkg::IECS_IDLE;
      flush_r       <= 1'b0;
      push_r        <= 1'b0;
      push_pc_r     <= '0;
      pc_load_r     <= 1'b0;
      pc_load_val_r <= '0;
      pop_r         <= 1'b0;
      restore_r     <= 1'b0;
      rdata_r       <= 8'h00;
    end else begin
      state_r       <= state_nxt;
      flush_r       <= take;
      push_r        <= take;
      push_pc_r     <= take ? core_pc : push_pc_r;
      pc_load_r     <= (state_r == iecs_pkg::IECS_VECT);
      pc_load_val_r <= iecs_pkg::IRQ_VECTOR;
      pop_r         <= ret_ok && !take;
      restore_r     <= ret_ok && !take;
      rdata_r       <= rd ? rd_val : 8'h00;
    end
  end

  // ****************************************************************
  // shadow copies
  // ****************************************************************
  for (genvar i = 0; i < iecs_pkg::SHADOW_COUNT; i++) begin : g_shadow
    wire sw_wr = wr && sh_hit && (sh_idx == 3'(i));
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        shadow_r[i] <= 8'h00;
      end else if (take) begin
        shadow_r[i] <= ctx_in[i];
      end else if (sw_wr) begin
        shadow_r[i] <= wdata;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata             = rdata_r;
  assign flush             = flush_r;
  assign stack_push        = push_r;
  assign push_pc           = push_pc_r;
  assign pc_load           = pc_load_r;
  assign pc_load_val       = pc_load_val_r;
  assign stack_pop         = pop_r;
  assign ctx_restore       = restore_r;
  assign rst_w             = shadow_r[iecs_pkg::SH_W];
  assign rst_status        = shadow_r[iecs_pkg::SH_STATUS];
  assign rst_bank_sel      = shadow_r[iecs_pkg::SH_BANK];
  assign rst_pc_hi         = shadow_r[iecs_pkg::SH_PCHI];
  assign rst_fsr0l         = shadow_r[iecs_pkg::SH_FSR0L];
  assign rst_fsr0h         = shadow_r[iecs_pkg::SH_FSR0H];
  assign rst_fsr1l         = shadow_r[iecs_pkg::SH_FSR1L];
  assign rst_fsr1h         = shadow_r[iecs_pkg::SH_FSR1H];
  assign global_irq_enable = glb_en;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence entry_s;
    flush_r && push_r ##1 pc_load_r && (pc_load_val_r == iecs_pkg::IRQ_VECTOR);
  endsequence

  entry_seq_a: assert property (take |=> entry_s)
    else $error("entry sequence wrong");
  gie_clear_a: assert property (take |=> !global_irq_enable)
    else $error("global enable not cleared on entry");
  save_w_a: assert property (take |=> (rst_w == $past(core_w)) &&
                             (push_pc == $past(core_pc)))
    else $error("working register or pc not saved");
  save_status_a: assert property (take |=>
      rst_status == ($past(core_status) & iecs_pkg::STATUS_SAVE_MASK))
    else $error("status shadow wrong");
  return_a: assert property (ret_ok && !take |=> ctx_restore && stack_pop &&
                             global_irq_enable)
    else $error("return did not restore");
  shadow_wr_a: assert property (wr && sh_hit && (sh_idx == 3'd0) && !take |=>
                                rst_w == $past(wdata))
    else $error("shadow write lost");
  gated_a: assert property (pc_load_r |-> $past(global_irq_enable, 2))
    else $error("vector taken with global enable off");
  group_a: assert property ($rose(pend_r) && !$past(grp_en) |-> $past(|src0))
    else $error("peripheral source passed without group enable");
  ext_flag_a: assert property (ext_edge |=> ext_flag_r)
    else $error("external edge did not set flag");
  ctrl_rd_a: assert property (rd && (addr == iecs_pkg::CTRL_ADDR) && !take && !ret_ok |=>
                              (rdata[5:1] == 5'h00) && (rdata == ctrl_r))
    else $error("control read wrong");

endmodule : iecs_irq_ctrl
`default_nettype wire

// File: iecs_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// core side: program counter, stack, live registers
// ****************************************************************
module iecs_core_model #(
  parameter logic [14:0] START_PC = 15'h0123
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scramble,
  input  wire logic        stack_push,
  input  wire logic [14:0] push_pc,
  input  wire logic        pc_load,
  input  wire logic [14:0] pc_load_val,
  input  wire logic        stack_pop,
  input  wire logic        ctx_restore,
  input  wire logic [63:0] shadow_bus,
  output logic      [14:0] core_pc,
  output logic      [63:0] live_bus
);
  logic [14:0] stk_r [16];
  logic [3:0]  sp_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_r     <= 4'h0;
      core_pc  <= START_PC;
      live_bus <= 64'h27262524_2322ff11;
    end else begin
      if (stack_push) begin
        stk_r[sp_r] <= push_pc;
        sp_r        <= sp_r + 4'h1;
      end
      if (pc_load)
        core_pc <= pc_load_val;
      if (stack_pop) begin
        sp_r    <= sp_r - 4'h1;
        core_pc <= stk_r[sp_r - 4'h1];
      end
      // service routine edits live registers, return reloads them
      if (ctx_restore)
        live_bus <= shadow_bus;
      else if (scramble)
        live_bus <= ~live_bus;
    end
  end
endmodule : iecs_core_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ****************************************************************
  // stimulus and wiring
  // ****************************************************************
  localparam logic [14:0] START = 15'h0123;
  localparam logic [11:0] SHW   = {iecs_pkg::SHADOW_BANK, iecs_pkg::SHADOW_BASE};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        scramble = 1'b0;
  logic        t0f = 1'b0;
  logic        iocf = 1'b0;
  logic        irq_ret = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  pflags = 8'h00;
  logic [7:0]  gpio = 8'h00;
  logic [7:0]  rdata;
  logic        flush, push, pload, pop, restore, glb_en;
  logic [14:0] cpc, ppc, lval;
  logic [63:0] shv, live;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #12.5 clk = ~clk;

  iecs_irq_ctrl iecs_irq_ctrl_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .gpio_pins(gpio), .tmr0_flag(t0f), .ioc_flag(iocf), .periph_flags(pflags),
    .core_irq_return(irq_ret), .core_pc(cpc), .core_w(live[7:0]),
    .core_status(live[15:8]), .core_bank_sel(live[23:16]), .core_pc_hi(live[31:24]),
    .core_fsr0l(live[39:32]),
    .core_fsr0h(live[47:40]), .core_fsr1l(live[55:48]), .core_fsr1h(live[63:56]),
    .flush(flush), .stack_push(push), .push_pc(ppc), .pc_load(pload), .pc_load_val(lval),
    .stack_pop(pop), .ctx_restore(restore), .rst_w(shv[7:0]), .rst_status(shv[15:8]),
    .rst_bank_sel(shv[23:16]), .rst_pc_hi(shv[31:24]), .rst_fsr0l(shv[39:32]),
    .rst_fsr0h(shv[47:40]), .rst_fsr1l(shv[55:48]), .rst_fsr1h(shv[63:56]),
    .global_irq_enable(glb_en)
  );

  iecs_core_model #(.START_PC(START)) iecs_core_model_i (
    .clk(clk), .rst_n(rst_n), .scramble(scramble), .stack_push(push), .push_pc(ppc),
    .pc_load(pload), .pc_load_val(lval), .stack_pop(pop), .ctx_restore(restore),
    .shadow_bus(shv), .core_pc(cpc), .live_bus(live)
  );

  // ****************************************************************
  // bus, entry and return tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), 64'(e), 64'(rdata));
  endtask : rd_chk

  task automatic take(input logic want, input int lat);
    int n;
    n = 0;
    while (flush !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("taken", 64'(want), 64'(flush));
    if (want && flush !== 1'b1)
      tally_and_finish();
    if (want) begin
      if (lat > 0)
        chk("latency", 64'(lat), 64'(n));
      chk("global enable after take", 64'h0, 64'(glb_en));
      chk("pushed pc", 64'(START), 64'(ppc));
      @(posedge clk);
      #1;
      chk("pc load", 64'h1, 64'(pload));
      chk("vector", 64'h4, 64'(lval));
      @(posedge clk);
      #1;
      chk("core pc", 64'h4, 64'(cpc));
    end
  endtask : take

  task automatic ret;
    @(posedge clk);
    t0f    <= 1'b0;
    iocf   <= 1'b0;
    pflags <= 8'h00;
    wr_reg(iecs_pkg::STAT_ADDR, 8'h00);
    @(posedge clk);
    irq_ret <= 1'b1;
    @(posedge clk);
    irq_ret <= 1'b0;
    #1;
    chk("pop", 64'h1, 64'(pop));
    chk("restore", 64'h1, 64'(restore));
    chk("global enable after return", 64'h1, 64'(glb_en));
    @(posedge clk);
    #1;
    chk("return pc", 64'(START), 64'(cpc));
  endtask : ret

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(iecs_pkg::CTRL_ADDR, 8'h01);
    rd_chk(iecs_pkg::EN0_ADDR, 8'h00);
    rd_chk(iecs_pkg::EN1_ADDR, 8'h00);
    wr_reg(iecs_pkg::CTRL_ADDR, 8'h7f);
    rd_chk(iecs_pkg::CTRL_ADDR, 8'h41);
    wr_reg(iecs_pkg::EN0_ADDR, 8'hff);
    rd_chk(iecs_pkg::EN0_ADDR, 8'h31);
    wr_reg(iecs_pkg::EN1_ADDR, 8'hff);
    rd_chk(iecs_pkg::EN1_ADDR, 8'hff);
    wr_reg(12'h123, 8'hff);
    rd_chk(12'h123, 8'h00);
    wr_reg(iecs_pkg::EN1_ADDR, 8'h00);
    wr_reg(iecs_pkg::EN0_ADDR, 8'h20);
    wr_reg(iecs_pkg::CTRL_ADDR, 8'h81);
    @(posedge clk);
    t0f <= 1'b1;
    take(1'b1, 2);
    chk("shadows", 64'h27262524_2322e711, shv);
    @(posedge clk);
    scramble <= 1'b1;
    @(posedge clk);
    scramble <= 1'b0;
    wr_reg(SHW, 8'h3c);
    rd_chk(SHW, 8'h3c);
    ret();
    chk("live regs", 64'h27262524_2322e73c, live);
    wr_reg(iecs_pkg::CTRL_ADDR, 8'hc1);
    for (int i = 0; i < 8; i++) begin
      wr_reg(iecs_pkg::EN1_ADDR, 8'h01 << i);
      @(posedge clk);
      pflags <= 8'h01 << i;
      take(1'b1, 2);
      ret();
    end
    wr_reg(iecs_pkg::CTRL_ADDR, 8'h81);
    @(posedge clk);
    pflags <= 8'h80;
    take(1'b0, 0);
    wr_reg(iecs_pkg::EN0_ADDR, 8'h10);
    @(posedge clk);
    iocf <= 1'b1;
    take(1'b1, 2);
    ret();
    wr_reg(iecs_pkg::EN0_ADDR, 8'h00);
    @(posedge clk);
    iocf <= 1'b1;
    t0f  <= 1'b1;
    take(1'b0, 0);
    wr_reg(iecs_pkg::CTRL_ADDR, 8'h01);
    wr_reg(iecs_pkg::EN0_ADDR, 8'h30);
    take(1'b0, 0);
    @(posedge clk);
    iocf <= 1'b0;
    t0f  <= 1'b0;
    wr_reg(iecs_pkg::PINSEL_ADDR, 8'h03);
    @(posedge clk);
    gpio <= 8'h08;
    repeat (8) @(posedge clk);
    rd_chk(iecs_pkg::STAT_ADDR, 8'h05);
    wr_reg(iecs_pkg::STAT_ADDR, 8'h00);
    rd_chk(iecs_pkg::STAT_ADDR, 8'h04);
    @(posedge clk);
    gpio <= 8'h0c;
    repeat (8) @(posedge clk);
    rd_chk(iecs_pkg::STAT_ADDR, 8'h04);
    wr_reg(iecs_pkg::EN0_ADDR, 8'h01);
    wr_reg(iecs_pkg::CTRL_ADDR, 8'h80);
    @(posedge clk);
    gpio <= 8'h04;
    take(1'b1, 0);
    ret();
    @(posedge clk);
    gpio <= 8'h0c;
    take(1'b0, 0);
    rd_chk(iecs_pkg::STAT_ADDR, 8'h04);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
